// [shared/sal_pkg.sv]
// constants for the secure area lock and write alignment block
package sal_pkg;
	// register byte offsets
	localparam logic [7:0] SAL_OFF_CTRL      = 8'h00;
	localparam logic [7:0] SAL_OFF_FEATURE   = 8'h04;
	localparam logic [7:0] SAL_OFF_SECOPT    = 8'h08;
	localparam logic [7:0] SAL_OFF_PROG_ADDR = 8'h0C;
	localparam logic [7:0] SAL_OFF_STATUS    = 8'h10;
	localparam logic [7:0] SAL_OFF_EXIT_KEY  = 8'h14;
	localparam logic [7:0] SAL_OFF_EXIT_ADDR = 8'h18;
	localparam logic [7:0] SAL_OFF_EXIT_GO   = 8'h1C;
	localparam logic [7:0] SAL_OFF_IRQ_STAT  = 8'h20;
	localparam logic [7:0] SAL_OFF_IRQ_CLR   = 8'h24;
	localparam logic [7:0] SAL_OFF_IRQ_EN    = 8'h28;
	// field positions
	localparam int SAL_CTRL_LOCK_BIT   = 0;
	localparam int SAL_FEAT_ALIGN8_BIT = 0;
	localparam int SAL_GO_START_BIT    = 0;
	localparam int SAL_GO_PARAM_BIT    = 1;
	localparam int SAL_ST_OK_BIT       = 0;
	localparam int SAL_ST_FAIL_BIT     = 1;
	localparam int SAL_ST_LOCK_BIT     = 2;
	localparam int SAL_ST_BUSY_BIT     = 3;
	localparam int SAL_EV_PROG_FAIL    = 0;
	localparam int SAL_EV_EXIT_DONE    = 1;
	localparam int SAL_EV_ACC_BLOCK    = 2;
	localparam int SAL_EV_KEY_ERR      = 3;
	localparam int SAL_EV_W            = 4;
	// values after reset
	localparam logic [7:0]  SAL_PAGES_RST  = 8'h00;
	localparam logic        SAL_ALIGN8_RST = 1'b0;
	// flash geometry
	localparam logic [31:0] SAL_FLASH_BASE = 32'h0800_0000;
	localparam int          SAL_PAGE_SHIFT = 11;
	// exit routine keys and entry points
	localparam logic [31:0] SAL_KEY_BANK1  = 32'h0819_2A3C;
	localparam logic [31:0] SAL_KEY_BANK2  = 32'h0819_2A3D;
	localparam logic [31:0] SAL_ENTRY_A    = 32'h1FFF_6800;
	localparam logic [31:0] SAL_ENTRY_B    = 32'h1FFF_1E00;
	// exit sequencer states
	typedef enum logic [1:0] {
		SAL_EXIT_IDLE = 2'b00,
		SAL_EXIT_LOCK = 2'b01,
		SAL_EXIT_JUMP = 2'b10
	} sal_exit_e;
endpackage : sal_pkg

// [verilog/sal_prog_check.sv]
// program address alignment checker with sticky failure
`timescale 1ns/1ns
module sal_prog_check
	import sal_pkg::*;
(
	input  wire logic        core_clk_i,    // system clock
	input  wire logic        rst_i,         // sync reset, active high
	input  wire logic        req_i,         // program request pulse
	input  wire logic [31:0] addr_i,        // program address
	input  wire logic        align8_i,      // 1: eight byte alignment
	output logic             ok_o,          // last request accepted
	output logic             fail_o,        // one-cycle failure pulse
	output logic             fail_sticky_o, // failed since reset
	output logic             prog_req_o,    // pulse to flash programmer
	output logic [31:0]      prog_addr_o    // address to programmer
);
	logic        ok_reg, ok_next;
	logic        fail_reg, fail_next;
	logic        sticky_reg, sticky_next;
	logic        preq_reg, preq_next;
	logic [31:0] paddr_reg, paddr_next;
	logic        misaligned;

	// eight byte mode also refuses addresses that are only four aligned
	assign misaligned = align8_i ? (addr_i[2:0] != 3'h0) : (addr_i[1:0] != 2'h0);

	// once one request failed every later one fails too
	always_comb begin
		ok_next     = ok_reg;
		fail_next   = 1'b0;
		sticky_next = sticky_reg;
		preq_next   = 1'b0;
		paddr_next  = paddr_reg;
		if (req_i) begin
			if (misaligned || sticky_reg) begin
				ok_next     = 1'b0;
				fail_next   = 1'b1;
				sticky_next = 1'b1;
			end else begin
				ok_next    = 1'b1;
				preq_next  = 1'b1;
				paddr_next = addr_i;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ok_reg     <= 1'b0;
			fail_reg   <= 1'b0;
			sticky_reg <= 1'b0;
			preq_reg   <= 1'b0;
			paddr_reg  <= 32'h0000_0000;
		end else begin
			ok_reg     <= ok_next;
			fail_reg   <= fail_next;
			sticky_reg <= sticky_next;
			preq_reg   <= preq_next;
			paddr_reg  <= paddr_next;
		end
	end

	assign ok_o          = ok_reg;
	assign fail_o        = fail_reg;
	assign fail_sticky_o = sticky_reg;
	assign prog_req_o    = preq_reg;
	assign prog_addr_o   = paddr_reg;

	// a failure is remembered until reset
	chk_sticky_fail_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sticky_reg |=> sticky_reg)
		else $error("sticky failure cleared");
	chk_after_fail_refused: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(sticky_reg && req_i) |=> (fail_reg && !preq_reg))
		else $error("request after failure passed");
	// four aligned is not good enough in eight byte mode
	chk_align8_refused: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(req_i && align8_i && addr_i[2:0] == 3'h4) |=> fail_reg)
		else $error("four aligned accepted in eight mode");
	chk_align4_passes: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(req_i && !align8_i && addr_i[1:0] == 2'h0 && !sticky_reg)
		|=> (preq_reg && paddr_reg == $past(addr_i)))
		else $error("aligned request not issued");
	cov_prog_fail: cover property (@(posedge core_clk_i) disable iff (rst_i) fail_reg);
endmodule : sal_prog_check

// [verilog/sal_secure_lock.sv]
// securable boot area lock, exit sequencer and apb register file
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
module sal_secure_lock
	import sal_pkg::*;
#(
	parameter bit DUAL_BANK    = 1'b0, // part has two flash banks
	parameter bit ALIGN_CHG    = 1'b1, // alignment may be changed by software
	parameter bit ENTRY_VAR_B  = 1'b0  // selects the second entry address
)(
	input  wire logic        core_clk_i,   // system clock, 20 MHz
	input  wire logic        rst_i,        // sync reset, active high
	input  wire logic        psel,         // apb select
	input  wire logic        penable,      // apb enable
	input  wire logic        pwrite,       // apb direction
	input  wire logic [31:0] paddr,        // apb address
	input  wire logic [31:0] pwdata,       // apb write data
	output logic             pready,       // apb ready
	output logic [31:0]      prdata,       // apb read data
	output logic             pslverr,      // apb error
	input  wire logic        acc_valid_i,  // flash read or fetch request
	input  wire logic [31:0] acc_addr_i,   // address of that access
	output logic             acc_done_o,   // access answered
	output logic             acc_err_o,    // bus error for the access
	output logic             prog_req_o,   // aligned program request pulse
	output logic [31:0]      prog_addr_o,  // aligned program address
	output logic             jump_valid_o, // jump to application pulse
	output logic [31:0]      jump_addr_o,  // application address
	output logic             jump_bank2_o, // jump target lies in bank two
	output logic             lock_o,       // secure area locked
	output logic [31:0]      exit_entry_o, // exit routine entry address
	output logic             irq_o         // level interrupt
);
	logic        lock_reg, lock_next;
	logic        align8_reg, align8_next;
	logic [7:0]  pages_reg, pages_next;
	logic [31:0] key_reg, key_next;
	logic [31:0] uaddr_reg, uaddr_next;
	logic        param_reg, param_next;
	sal_exit_e   state_reg, state_next;
	logic        jv_reg, jv_next;
	logic [31:0] ja_reg, ja_next;
	logic        jb2_reg, jb2_next;
	logic        adone_reg, adone_next;
	logic        aerr_reg, aerr_next;
	logic [SAL_EV_W-1:0] ist_reg, ist_next;
	logic [SAL_EV_W-1:0] ien_reg, ien_next;
	logic        wr_en, rd_en, mapped;
	logic [7:0]  off;
	logic [31:0] area_end;
	logic        prog_ok, prog_fail, prog_sticky;
	logic        key_err, exit_done, acc_block;
	logic        go_start, key_good;
	logic [SAL_EV_W-1:0] ev;

	// decode a register offset into a hit flag
	function automatic logic reg_hit(input logic [7:0] o, input logic [7:0] r);
		reg_hit = (o == r);
	endfunction : reg_hit

	// apb: zero wait states, writes land at the access edge
	assign off     = paddr[7:0];
	assign mapped  = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'h0) && (off <= SAL_OFF_IRQ_EN);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en   = psel && penable && pwrite && mapped;
	assign rd_en   = psel && penable && !pwrite && mapped;

	// first byte past the secure area, counted in whole pages
	assign area_end = SAL_FLASH_BASE + {13'h0000, pages_reg, 11'h000};

	sal_prog_check u_prog (
		.core_clk_i    (core_clk_i),
		.rst_i         (rst_i),
		.req_i         (wr_en && reg_hit(off, SAL_OFF_PROG_ADDR)),
		.addr_i        (pwdata),
		.align8_i      (align8_reg),
		.ok_o          (prog_ok),
		.fail_o        (prog_fail),
		.fail_sticky_o (prog_sticky),
		.prog_req_o    (prog_req_o),
		.prog_addr_o   (prog_addr_o)
	);

	// configuration: lock is write-once, page count frozen by the lock
	always_comb begin
		lock_next   = lock_reg;
		align8_next = align8_reg;
		pages_next  = pages_reg;
		key_next    = key_reg;
		uaddr_next  = uaddr_reg;
		param_next  = param_reg;
		go_start    = 1'b0;
		if (wr_en && reg_hit(off, SAL_OFF_CTRL) && pwdata[SAL_CTRL_LOCK_BIT])
			lock_next = 1'b1;
		if (state_reg == SAL_EXIT_LOCK)
			lock_next = 1'b1;
		if (ALIGN_CHG && wr_en && reg_hit(off, SAL_OFF_FEATURE))
			align8_next = pwdata[SAL_FEAT_ALIGN8_BIT];
		// the size cannot move once the area is hidden
		if (wr_en && reg_hit(off, SAL_OFF_SECOPT) && !lock_reg)
			pages_next = pwdata[7:0];
		if (wr_en && reg_hit(off, SAL_OFF_EXIT_KEY))
			key_next = pwdata;
		if (wr_en && reg_hit(off, SAL_OFF_EXIT_ADDR))
			uaddr_next = pwdata;
		if (wr_en && reg_hit(off, SAL_OFF_EXIT_GO) && pwdata[SAL_GO_START_BIT]
				&& state_reg == SAL_EXIT_IDLE) begin
			go_start   = 1'b1;
			param_next = pwdata[SAL_GO_PARAM_BIT];
		end
	end

	// 3D is only meaningful on a two bank part
	assign key_good = (key_reg == SAL_KEY_BANK1) || (DUAL_BANK && key_reg == SAL_KEY_BANK2);
	assign key_err  = go_start && pwdata[SAL_GO_PARAM_BIT] && !key_good;

	// exit sequence: lock first, then jump, so the area is hidden before any fetch
	always_comb begin
		state_next = state_reg;
		jv_next    = 1'b0;
		ja_next    = ja_reg;
		jb2_next   = jb2_reg;
		unique case (state_reg)
			SAL_EXIT_IDLE: begin
				if (go_start && !key_err)
					state_next = SAL_EXIT_LOCK;
			end
			SAL_EXIT_LOCK: begin
				state_next = SAL_EXIT_JUMP;
			end
			SAL_EXIT_JUMP: begin
				state_next = SAL_EXIT_IDLE;
				jv_next    = 1'b1;
				if (param_reg) begin
					// no check of the user address: a bad one is the caller's fault
					ja_next  = uaddr_reg;
					jb2_next = DUAL_BANK && (key_reg == SAL_KEY_BANK2);
				end else begin
					ja_next  = area_end;
					jb2_next = 1'b0;
				end
			end
			default: state_next = SAL_EXIT_IDLE;
		endcase
	end
	assign exit_done = jv_reg;

	// reads and fetches inside the hidden area answer with an error
	assign acc_block = acc_valid_i && lock_reg && (acc_addr_i >= SAL_FLASH_BASE)
		&& (acc_addr_i < area_end);
	always_comb begin
		adone_next = acc_valid_i;
		aerr_next  = acc_block;
	end

	// events set sticky bits; a set in the clear cycle wins
	assign ev = {key_err, acc_block, exit_done, prog_fail};
	always_comb begin
		ist_next = ist_reg;
		ien_next = ien_reg;
		if (wr_en && reg_hit(off, SAL_OFF_IRQ_CLR))
			ist_next = ist_next & ~pwdata[SAL_EV_W-1:0];
		ist_next = ist_next | ev;
		if (wr_en && reg_hit(off, SAL_OFF_IRQ_EN))
			ien_next = pwdata[SAL_EV_W-1:0];
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			lock_reg   <= 1'b0;
			align8_reg <= SAL_ALIGN8_RST;
			pages_reg  <= SAL_PAGES_RST;
			key_reg    <= 32'h0000_0000;
			uaddr_reg  <= 32'h0000_0000;
			param_reg  <= 1'b0;
			state_reg  <= SAL_EXIT_IDLE;
			jv_reg     <= 1'b0;
			ja_reg     <= 32'h0000_0000;
			jb2_reg    <= 1'b0;
			adone_reg  <= 1'b0;
			aerr_reg   <= 1'b0;
			ist_reg    <= '0;
			ien_reg    <= '0;
		end else begin
			lock_reg   <= lock_next;
			align8_reg <= align8_next;
			pages_reg  <= pages_next;
			key_reg    <= key_next;
			uaddr_reg  <= uaddr_next;
			param_reg  <= param_next;
			state_reg  <= state_next;
			jv_reg     <= jv_next;
			ja_reg     <= ja_next;
			jb2_reg    <= jb2_next;
			adone_reg  <= adone_next;
			aerr_reg   <= aerr_next;
			ist_reg    <= ist_next;
			ien_reg    <= ien_next;
		end
	end

	// read mux; write-only registers read zero
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			unique case (off)
				SAL_OFF_CTRL:      prdata[SAL_CTRL_LOCK_BIT] = lock_reg;
				SAL_OFF_FEATURE:   prdata[SAL_FEAT_ALIGN8_BIT] = align8_reg;
				SAL_OFF_SECOPT:    prdata[7:0] = pages_reg;
				SAL_OFF_PROG_ADDR: prdata = prog_addr_o;
				SAL_OFF_STATUS:    prdata[SAL_ST_BUSY_BIT:0] =
					{state_reg != SAL_EXIT_IDLE, lock_reg, prog_sticky, prog_ok};
				SAL_OFF_EXIT_KEY:  prdata = key_reg;
				SAL_OFF_EXIT_ADDR: prdata = uaddr_reg;
				SAL_OFF_IRQ_STAT:  prdata[SAL_EV_W-1:0] = ist_reg;
				SAL_OFF_IRQ_EN:    prdata[SAL_EV_W-1:0] = ien_reg;
				default:           prdata = 32'h0000_0000;
			endcase
		end
	end

	assign acc_done_o   = adone_reg;
	assign acc_err_o    = aerr_reg;
	assign jump_valid_o = jv_reg;
	assign jump_addr_o  = ja_reg;
	assign jump_bank2_o = jb2_reg;
	assign lock_o       = lock_reg;
	assign exit_entry_o = ENTRY_VAR_B ? SAL_ENTRY_B : SAL_ENTRY_A;
	assign irq_o        = |(ist_reg & ien_reg);

	// the lock only ever rises; reset is the one way back
	chk_lock_never_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
		lock_reg |=> lock_reg)
		else $error("lock bit cleared without reset");
	// a control write of one shows as lock from the next cycle on
	chk_lock_write_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wr_en && off == SAL_OFF_CTRL && pwdata[SAL_CTRL_LOCK_BIT]) |=> lock_o)
		else $error("lock write ignored");
	// the area must be hidden before the core can fetch from the target
	chk_exit_lock_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$rose(jv_reg) |-> ($past(lock_reg) && lock_reg))
		else $error("jump before lock");
	chk_exit_two_cycles: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state_reg == SAL_EXIT_IDLE && go_start && !key_err) |-> ##2 (lock_reg ##1 jv_reg))
		else $error("exit sequence timing");
	// a jump is a single pulse; the next one needs a fresh start write
	chk_jump_one_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
		jv_reg |=> !jv_reg)
		else $error("jump pulse longer than one cycle");
	// a refused key neither locks nor starts the sequencer
	chk_bad_key_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(key_err && !lock_reg) |=> (!lock_reg && state_reg == SAL_EXIT_IDLE))
		else $error("wrong key started the exit");
	// without parameters the target is the first byte past the area
	chk_noparam_target: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(jv_reg && !$past(param_reg)) |-> (ja_reg == area_end))
		else $error("jump not past area");
	chk_bank2_key: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(jv_reg && jb2_reg) |-> (DUAL_BANK && key_reg == SAL_KEY_BANK2))
		else $error("bank two without key");
	// hidden reads answer with an error and never with data
	chk_hidden_error: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(acc_valid_i && lock_reg && acc_addr_i == SAL_FLASH_BASE && pages_reg != 8'h00)
		|=> (acc_done_o && acc_err_o))
		else $error("secure area readable while locked");
	chk_open_no_error: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(acc_valid_i && !lock_reg) |=> !acc_err_o)
		else $error("error while unlocked");
	chk_err_has_done: assert property (@(posedge core_clk_i) disable iff (rst_i)
		acc_err_o |-> acc_done_o)
		else $error("bus error without an answer");
	// the size cannot move under a hidden area
	chk_pages_frozen: assert property (@(posedge core_clk_i) disable iff (rst_i)
		lock_reg |=> $stable(pages_reg))
		else $error("page count changed while locked");
	// a blocked access is flagged even when software clears in the same cycle
	chk_block_event_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
		acc_block |=> ist_reg[SAL_EV_ACC_BLOCK])
		else $error("blocked access not flagged");

	// main scenarios
	cov_exit_param: cover property (@(posedge core_clk_i) disable iff (rst_i) jv_reg && param_reg);
	cov_exit_plain: cover property (@(posedge core_clk_i) disable iff (rst_i) jv_reg && !param_reg);
	cov_blocked: cover property (@(posedge core_clk_i) disable iff (rst_i) acc_err_o && irq_o);
	cov_key_refused: cover property (@(posedge core_clk_i) disable iff (rst_i) key_err);
endmodule : sal_secure_lock

// [sim/sal_boot_core.sv]
// boot code model on the core side: issues flash reads and fetches, collects answers
`timescale 1ns/1ns
module sal_boot_core (
	input  wire logic        core_clk_i,   // system clock
	input  wire logic        rst_i,        // sync reset, active high
	input  wire logic        fetch_go_i,   // start one access
	input  wire logic [31:0] fetch_addr_i, // address of that access
	output logic             acc_valid_o,  // request towards the block
	output logic [31:0]      acc_addr_o,   // request address
	input  wire logic        acc_done_i,   // block answered
	input  wire logic        acc_err_i,    // block raised a bus error
	output logic             done_o,       // answer seen last cycle
	output logic             err_o         // error flag of last answer
);
	// one request per go pulse; idle address flips so a stale value never looks valid
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			acc_valid_o <= 1'b0;
			acc_addr_o  <= 32'h0;
			done_o      <= 1'b0;
			err_o       <= 1'b0;
		end else begin
			acc_valid_o <= fetch_go_i;
			acc_addr_o  <= fetch_go_i ? fetch_addr_i : ~acc_addr_o;
			done_o      <= acc_done_i;
			if (acc_done_i) begin
				err_o <= acc_err_i;
			end
		end
	end
endmodule : sal_boot_core

// [sim/sal_secure_lock_tb_top.sv]
// self-checking bench for the secure area lock and program alignment block
`timescale 1ns/1ns
`define CHK(g, e) \
	begin \
		tests_run++; \
		if ((g) !== (e)) begin \
			fails++; \
			$display("ERROR %0t: got %h exp %h", $time, (g), (e)); \
		end \
	end
module sal_secure_lock_tb_top;
	import sal_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        rst_i      = 1'b1;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [31:0] paddr      = 32'h0;
	logic [31:0] pwdata     = 32'h0;
	logic        fgo        = 1'b0;
	logic [31:0] faddr      = 32'h0;
	logic        pready, pslverr, acc_valid_i, acc_done_o, acc_err_o, prog_req_o;
	logic        jump_valid_o, jump_bank2_o, lock_o, irq_o, fdone, ferr, err;
	logic [31:0] prdata, acc_addr_i, prog_addr_o, jump_addr_o, exit_entry_o, rd;
	logic [31:0] keys [3] = '{SAL_KEY_BANK1, SAL_KEY_BANK2, 32'h0819_2A3E};
	int          fails = 0;
	int          tests_run = 0;
	int          cyc = 0;

	// dual bank part so both exit keys are reachable
	sal_secure_lock #(.DUAL_BANK(1'b1), .ALIGN_CHG(1'b1), .ENTRY_VAR_B(1'b0)) uut (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .acc_valid_i(acc_valid_i),
		.acc_addr_i(acc_addr_i), .acc_done_o(acc_done_o), .acc_err_o(acc_err_o),
		.prog_req_o(prog_req_o), .prog_addr_o(prog_addr_o), .jump_valid_o(jump_valid_o),
		.jump_addr_o(jump_addr_o), .jump_bank2_o(jump_bank2_o), .lock_o(lock_o),
		.exit_entry_o(exit_entry_o), .irq_o(irq_o));

	sal_boot_core boot (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .fetch_go_i(fgo), .fetch_addr_i(faddr),
		.acc_valid_o(acc_valid_i), .acc_addr_o(acc_addr_i), .acc_done_i(acc_done_o),
		.acc_err_i(acc_err_o), .done_o(fdone), .err_o(ferr));

	// 20 MHz clock
	always #25 core_clk_i = ~core_clk_i;

	// cut a hang short; the whole run needs well under a thousand cycles
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	// one apb transfer; the request is held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge core_clk_i);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= {24'h0, a};
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		@(posedge core_clk_i);
		// only the bench timeout ends a wait for the slave
		while (pready !== 1'b1) begin
			@(posedge core_clk_i);
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, err);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, rd, err);
		`CHK({err, rd}, {1'b0, x})
	endtask : rdc

	// program request; the pulse stands for the one cycle after the write edge
	task automatic prog(input logic [31:0] a, input logic ok);
		wr(SAL_OFF_PROG_ADDR, a);
		#1;
		`CHK(prog_req_o, ok)
	endtask : prog

	// exit start: lock one edge after the write edge, jump pulse one edge later
	task automatic exit_chk(input logic [31:0] go, input logic j, input logic [31:0] ja,
			input logic b2);
		wr(SAL_OFF_EXIT_GO, go);
		@(posedge core_clk_i);
		#1;
		`CHK({lock_o, jump_valid_o}, {j, 1'b0})
		@(posedge core_clk_i);
		#1;
		`CHK({jump_valid_o, jump_addr_o & {32{j}}, jump_bank2_o}, {j, ja, b2})
	endtask : exit_chk

	task automatic fetch(input logic [31:0] a, input logic e);
		int k;
		@(posedge core_clk_i);
		fgo   <= 1'b1;
		faddr <= a;
		@(posedge core_clk_i);
		fgo <= 1'b0;
		for (k = 0; k < 8 && fdone !== 1'b1; k++) @(posedge core_clk_i);
		`CHK({fdone, ferr}, {1'b1, e})
	endtask : fetch

	task automatic do_reset;
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
	endtask : do_reset

	// main sequence
	initial begin
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#1;
		`CHK({lock_o, irq_o, exit_entry_o}, {2'b00, SAL_ENTRY_A})
		rdc(SAL_OFF_STATUS, 32'h0);
		apb(1'b0, 8'h2C, 32'h0, rd, err);
		`CHK({err, rd}, {1'b1, 32'h0})
		prog(32'h0800_0014, 1'b1);
		`CHK(prog_addr_o, 32'h0800_0014)
		wr(SAL_OFF_IRQ_EN, 32'h1);
		prog(32'h0800_0012, 1'b0);
		prog(32'h0800_0010, 1'b0);
		rdc(SAL_OFF_STATUS, 32'h2);
		`CHK(irq_o, 1'b1)
		wr(SAL_OFF_IRQ_EN, 32'h0);
		rdc(SAL_OFF_IRQ_STAT, 32'h1);
		`CHK(irq_o, 1'b0)
		wr(SAL_OFF_IRQ_EN, 32'h1);
		rdc(SAL_OFF_IRQ_STAT, 32'h1);
		`CHK(irq_o, 1'b1)
		wr(SAL_OFF_IRQ_CLR, 32'h1);
		rdc(SAL_OFF_IRQ_STAT, 32'h0);
		`CHK(irq_o, 1'b0)
		$display("test four byte alignment done");
		do_reset();
		wr(SAL_OFF_FEATURE, 32'h1);
		rdc(SAL_OFF_FEATURE, 32'h1);
		prog(32'h0800_0010, 1'b1);
		prog(32'h0800_0014, 1'b0);
		prog(32'h0800_0018, 1'b0);
		$display("test eight byte alignment done");
		do_reset();
		wr(SAL_OFF_SECOPT, 32'h3);
		fetch(32'h0800_1000, 1'b0);
		exit_chk(32'h1, 1'b1, 32'h0800_1800, 1'b0);
		fetch(32'h0800_0000, 1'b1);
		fetch(32'h0800_17FC, 1'b1);
		fetch(32'h0800_1800, 1'b0);
		fetch(32'h07FF_FFFC, 1'b0);
		rdc(SAL_OFF_IRQ_STAT, 32'h6);
		wr(SAL_OFF_CTRL, 32'h0);
		rdc(SAL_OFF_CTRL, 32'h1);
		wr(SAL_OFF_SECOPT, 32'h5);
		rdc(SAL_OFF_SECOPT, 32'h3);
		do_reset();
		rdc(SAL_OFF_CTRL, 32'h0);
		fetch(32'h0800_0000, 1'b0);
		wr(SAL_OFF_CTRL, 32'h1);
		rdc(SAL_OFF_CTRL, 32'h1);
		$display("test secure lock done");
		// keyed exits: bank one, bank two and a wrong key; the block jumps to the odd target without checking it
		for (int i = 0; i < 3; i++) begin
			do_reset();
			wr(SAL_OFF_EXIT_KEY, keys[i]);
			wr(SAL_OFF_EXIT_ADDR, 32'h2000_0001);
			exit_chk(32'h3, i < 2, (i < 2) ? 32'h2000_0001 : 32'h0, i == 1);
			rdc(SAL_OFF_IRQ_STAT, (i < 2) ? 32'h2 : 32'h8);
		end
		$display("test exit keys done");
		report_and_stop();
	end
endmodule : sal_secure_lock_tb_top
